/* File: hw/qu_top.sv */
// four channel asynchronous serial transceiver core
`include "qu_defines.svh"

module qu_top #(
    parameter int CHANNELS = `QU_CHANNELS,
    parameter int FIFO_DEPTH = `QU_FIFO_DEPTH,
    parameter logic [1:0] IRQ_VARIANT = `QU_STYLE_PIN
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire qu_pkg::qu_cfg_s cfg_i,
    input wire qu_pkg::qu_sel_s sel_i,
    input wire logic wr_strobe_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_strobe_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [CHANNELS-1:0] loopback_i,
    input wire logic irq_style_select_i,
    input wire logic [CHANNELS-1:0] modem_control_reg_gate_i,
    input wire logic [CHANNELS-1:0] serial_in_ch_i,
    output logic [CHANNELS-1:0] serial_out_ch_o,
    output logic combined_rx_avail_n_o,
    output logic combined_tx_space_n_o,
    output logic [CHANNELS-1:0] irq_o,
    output logic [CHANNELS-1:0] line_err_o,
    output logic [CHANNELS-1:0] rx_pending_o
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // ***************************************************
    // channel select decode
    // ***************************************************
    function automatic logic [CHANNELS-1:0] chan_pick(input qu_pkg::qu_sel_s s);
        logic [CHANNELS-1:0] r;
        r = '0;
        if (s.mode_16) begin
            for (int k = 0; k < CHANNELS; k++) begin
                if (s.chan_cs_n == ~(4'h1 << k)) begin
                    r[k] = 1'b1;
                end
            end
        end else if (!s.single_cs_n) begin
            r[s.chan_addr] = 1'b1;
        end
        return r;
    endfunction : chan_pick

    function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
        logic [CW-1:0] r;
        case (sel)
            2'h0: r = CW'(`QU_TRIG_L0);
            2'h1: r = CW'(`QU_TRIG_L1);
            2'h2: r = CW'(`QU_TRIG_L2);
            default: r = CW'(`QU_TRIG_L3);
        endcase
        return r;
    endfunction : trig_level

    logic [CHANNELS-1:0] wr_pick;
    logic [CHANNELS-1:0] rd_pick;
    logic [CHANNELS-1:0] tx_space;
    logic [CHANNELS-1:0] rx_avail;
    logic [CHANNELS-1:0] irq_raw;
    logic [7:0] rx_head [CHANNELS];
    logic irq_continuous;

    assign wr_pick = wr_strobe_i ? chan_pick(sel_i) : '0;
    assign rd_pick = rd_strobe_i ? chan_pick(sel_i) : '0;

    // ***************************************************
    // interrupt style
    // ***************************************************
    always_comb begin
        case (IRQ_VARIANT)
            `QU_STYLE_TIED_HIGH: irq_continuous = 1'b1;
            `QU_STYLE_TIED_LOW: irq_continuous = 1'b0;
            default: irq_continuous = irq_style_select_i;
        endcase
    end

    // ***************************************************
    // per-channel transmitter and receiver
    // ***************************************************
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic [`QU_DIV_WIDTH-1:0] div_cnt_q;
        logic tick;
        logic rx_s1_q;
        logic rx_s2_q;
        logic rx_line;
        logic tx_line_q;
        qu_pkg::qu_state_e tx_st_q;
        qu_pkg::qu_state_e rx_st_q;
        logic [3:0] tx_sub_q;
        logic [3:0] rx_sub_q;
        logic [2:0] tx_bit_q;
        logic [2:0] rx_bit_q;
        logic tx_stop2_q;
        logic [7:0] tx_sh_q;
        logic [7:0] rx_sh_q;
        logic tx_par_q;
        logic rx_par_q;
        logic rx_par_err_q;
        logic tx_pop;
        logic tx_valid;
        logic [7:0] tx_data;
        logic rx_push;
        logic rx_ready;
        logic rx_frame_err;
        logic [CW-1:0] rx_count;

        // baud tick at sixteen times the bit rate
        assign tick = (div_cnt_q <= `QU_DIV_RESET);

        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                div_cnt_q <= `QU_DIV_RESET;
            end else if (tick) begin
                div_cnt_q <= cfg_i.baud_div;
            end else begin
                div_cnt_q <= div_cnt_q - 1'b1;
            end
        end

        // fifos: single location until enabled
        qu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) u_tx_fifo (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .limit_one_i(~cfg_i.fifo_en),
            .in_valid_i(wr_pick[c]),
            .in_ready_o(tx_space[c]),
            .in_data_i(wr_data_i),
            .out_valid_o(tx_valid),
            .out_ready_i(tx_pop),
            .out_data_o(tx_data),
            .count_o()
        );

        qu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_fifo (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .limit_one_i(~cfg_i.fifo_en),
            .in_valid_i(rx_push),
            .in_ready_o(rx_ready),
            .in_data_i(rx_sh_q),
            .out_valid_o(rx_avail[c]),
            .out_ready_i(rd_pick[c]),
            .out_data_o(rx_head[c]),
            .count_o(rx_count)
        );

        assign irq_raw[c] = cfg_i.fifo_en ? (rx_count >= trig_level(cfg_i.rx_trig)) : rx_avail[c];

        // ***************************************************
        // transmitter
        // ***************************************************
        assign tx_pop = (tx_st_q == qu_pkg::QU_IDLE) & tx_valid;

        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                tx_st_q <= qu_pkg::QU_IDLE;
                tx_line_q <= 1'b1;
                tx_sub_q <= '0;
                tx_bit_q <= '0;
                tx_stop2_q <= 1'b0;
                tx_sh_q <= '0;
                tx_par_q <= 1'b0;
            end else begin
                case (tx_st_q)
                    qu_pkg::QU_IDLE: begin
                        tx_line_q <= 1'b1;
                        if (tx_valid) begin
                            tx_sh_q <= tx_data;
                            tx_par_q <= (^tx_data) ^ cfg_i.parity_odd;
                            tx_sub_q <= '0;
                            tx_st_q <= qu_pkg::QU_START;
                        end
                    end
                    qu_pkg::QU_START: begin
                        tx_line_q <= 1'b0;
                        if (tick) begin
                            tx_sub_q <= tx_sub_q + 1'b1;
                            if (tx_sub_q == `QU_LAST_SAMPLE) begin
                                tx_bit_q <= '0;
                                tx_st_q <= qu_pkg::QU_DATA;
                            end
                        end
                    end
                    qu_pkg::QU_DATA: begin
                        tx_line_q <= tx_sh_q[0];
                        if (tick) begin
                            tx_sub_q <= tx_sub_q + 1'b1;
                            if (tx_sub_q == `QU_LAST_SAMPLE) begin
                                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                                tx_bit_q <= tx_bit_q + 1'b1;
                                if (tx_bit_q == `QU_LAST_DATA_BIT) begin
                                    tx_stop2_q <= cfg_i.two_stop;
                                    tx_st_q <= cfg_i.parity_en ? qu_pkg::QU_PARITY : qu_pkg::QU_STOP;
                                end
                            end
                        end
                    end
                    qu_pkg::QU_PARITY: begin
                        tx_line_q <= tx_par_q;
                        if (tick) begin
                            tx_sub_q <= tx_sub_q + 1'b1;
                            if (tx_sub_q == `QU_LAST_SAMPLE) begin
                                tx_st_q <= qu_pkg::QU_STOP;
                            end
                        end
                    end
                    qu_pkg::QU_STOP: begin
                        tx_line_q <= 1'b1;
                        if (tick) begin
                            tx_sub_q <= tx_sub_q + 1'b1;
                            if (tx_sub_q == `QU_LAST_SAMPLE) begin
                                tx_stop2_q <= 1'b0;
                                if (!tx_stop2_q) begin
                                    tx_st_q <= qu_pkg::QU_IDLE;
                                end
                            end
                        end
                    end
                    default: tx_st_q <= qu_pkg::QU_IDLE;
                endcase
            end
        end

        // external pin idles high during loop-back
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                serial_out_ch_o[c] <= 1'b1;
            end else begin
                serial_out_ch_o[c] <= loopback_i[c] ? 1'b1 : tx_line_q;
            end
        end

        // ***************************************************
        // receiver
        // ***************************************************
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                rx_s1_q <= 1'b1;
                rx_s2_q <= 1'b1;
            end else begin
                rx_s1_q <= serial_in_ch_i[c];
                rx_s2_q <= rx_s1_q;
            end
        end

        assign rx_line = loopback_i[c] ? tx_line_q : rx_s2_q;
        assign rx_push = (rx_st_q == qu_pkg::QU_STOP) & tick & (rx_sub_q == `QU_LAST_SAMPLE) & rx_line;
        assign rx_frame_err = (rx_st_q == qu_pkg::QU_STOP) & tick & (rx_sub_q == `QU_LAST_SAMPLE) & ~rx_line;

        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                rx_st_q <= qu_pkg::QU_IDLE;
                rx_sub_q <= '0;
                rx_bit_q <= '0;
                rx_sh_q <= '0;
                rx_par_q <= 1'b0;
                rx_par_err_q <= 1'b0;
            end else begin
                case (rx_st_q)
                    qu_pkg::QU_IDLE: begin
                        rx_sub_q <= '0;
                        if (!rx_line) begin
                            rx_st_q <= qu_pkg::QU_START;
                        end
                    end
                    qu_pkg::QU_START: begin
                        if (tick) begin
                            rx_sub_q <= rx_sub_q + 1'b1;
                            if (rx_sub_q == `QU_MID_SAMPLE) begin
                                // false start: line back high at mid-bit
                                rx_sub_q <= '0;
                                rx_bit_q <= '0;
                                rx_par_q <= cfg_i.parity_odd;
                                rx_par_err_q <= 1'b0;
                                rx_st_q <= rx_line ? qu_pkg::QU_IDLE : qu_pkg::QU_DATA;
                            end
                        end
                    end
                    qu_pkg::QU_DATA: begin
                        if (tick) begin
                            rx_sub_q <= rx_sub_q + 1'b1;
                            if (rx_sub_q == `QU_LAST_SAMPLE) begin
                                rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                                rx_par_q <= rx_par_q ^ rx_line;
                                rx_bit_q <= rx_bit_q + 1'b1;
                                if (rx_bit_q == `QU_LAST_DATA_BIT) begin
                                    rx_st_q <= cfg_i.parity_en ? qu_pkg::QU_PARITY : qu_pkg::QU_STOP;
                                end
                            end
                        end
                    end
                    qu_pkg::QU_PARITY: begin
                        if (tick) begin
                            rx_sub_q <= rx_sub_q + 1'b1;
                            if (rx_sub_q == `QU_LAST_SAMPLE) begin
                                rx_par_err_q <= rx_par_q ^ rx_line;
                                rx_st_q <= qu_pkg::QU_STOP;
                            end
                        end
                    end
                    qu_pkg::QU_STOP: begin
                        if (tick) begin
                            rx_sub_q <= rx_sub_q + 1'b1;
                            if (rx_sub_q == `QU_LAST_SAMPLE) begin
                                rx_st_q <= qu_pkg::QU_IDLE;
                            end
                        end
                    end
                    default: rx_st_q <= qu_pkg::QU_IDLE;
                endcase
            end
        end

        // sticky line error; a new error wins over the read that clears it
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                line_err_o[c] <= 1'b0;
            end else if (rx_frame_err || (rx_push && (rx_par_err_q || !rx_ready))) begin
                line_err_o[c] <= 1'b1;
            end else if (rd_pick[c]) begin
                line_err_o[c] <= 1'b0;
            end
        end

        // per-channel status for source identification
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                rx_pending_o[c] <= 1'b0;
                irq_o[c] <= 1'b0;
            end else begin
                rx_pending_o[c] <= rx_avail[c];
                irq_o[c] <= irq_raw[c] & (irq_continuous | modem_control_reg_gate_i[c]);
            end
        end
    end

    // ***************************************************
    // combined flags and read data
    // ***************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            combined_rx_avail_n_o <= 1'b1;
            combined_tx_space_n_o <= 1'b0;
        end else begin
            combined_rx_avail_n_o <= ~|rx_avail;
            combined_tx_space_n_o <= ~|tx_space;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= |(rd_pick & rx_avail);
            rd_data_o <= 8'h00;
            for (int k = 0; k < CHANNELS; k++) begin
                if (rd_pick[k]) begin
                    rd_data_o <= rx_head[k];
                end
            end
        end
    end

endmodule : qu_top

/* File: hw/qu_defines.svh */
// offsets, levels and timing counts for the quad channel serial core
`ifndef QU_DEFINES_SVH
`define QU_DEFINES_SVH

`define QU_CHANNELS 4
`define QU_FIFO_DEPTH 16
`define QU_DATA_BITS 8
`define QU_OVERSAMPLE 16
`define QU_MID_SAMPLE 4'h7
`define QU_LAST_SAMPLE 4'hF
`define QU_LAST_DATA_BIT 3'h7
`define QU_DIV_WIDTH 16
`define QU_DIV_RESET 16'h0001

// receive fill thresholds, selected by cfg.rx_trig
`define QU_TRIG_L0 5'h01
`define QU_TRIG_L1 5'h04
`define QU_TRIG_L2 5'h08
`define QU_TRIG_L3 5'h0E

// interrupt style variants
`define QU_STYLE_PIN 2'h0
`define QU_STYLE_TIED_HIGH 2'h1
`define QU_STYLE_TIED_LOW 2'h2

`endif

/* File: hw/qu_pkg.sv */
// types shared by the quad channel serial core
package qu_pkg;

    typedef enum logic [2:0] {
        QU_IDLE,
        QU_START,
        QU_DATA,
        QU_PARITY,
        QU_STOP
    } qu_state_e;

    typedef struct packed {
        logic fifo_en;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic [1:0] rx_trig;
        logic [15:0] baud_div;
    } qu_cfg_s;

    typedef struct packed {
        logic mode_16;
        logic [3:0] chan_cs_n;
        logic single_cs_n;
        logic [1:0] chan_addr;
    } qu_sel_s;

endpackage : qu_pkg

/* File: hw/qu_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
module qu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic limit_one_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [CW-1:0] count_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    // fifo-less mode: a single holding location
    assign in_ready_o = limit_one_i ? (count_q == '0) : (count_q != CW'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign count_o = count_q;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : qu_fifo

/* File: tb/qu_top_assertions.sv */
// concurrent checks on the serial core ports
module qu_top_assertions #(
    parameter int CHANNELS = 4,
    parameter logic [1:0] IRQ_VARIANT = 2'h0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    input wire logic rd_valid_o,
    input wire logic [CHANNELS-1:0] loopback_i,
    input wire logic irq_style_select_i,
    input wire logic [CHANNELS-1:0] modem_control_reg_gate_i,
    input wire logic [CHANNELS-1:0] serial_out_ch_o,
    input wire logic combined_rx_avail_n_o,
    input wire logic combined_tx_space_n_o,
    input wire logic [CHANNELS-1:0] irq_o,
    input wire logic [CHANNELS-1:0] line_err_o,
    input wire logic [CHANNELS-1:0] rx_pending_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_line_idle: assert property (disable iff (1'h0) !rst_n_i |=> serial_out_ch_o == '1)
        else $error("serial output not idle high after reset");
    a_loop_pin_idle: assert property ((loopback_i & $past(loopback_i) & ~serial_out_ch_o) == '0)
        else $error("transmit pin active during loop-back");
    a_rx_flag_any: assert property (rx_pending_o != '0 |-> ##[0:2] !combined_rx_avail_n_o)
        else $error("combined receive flag missed pending data");
    a_rx_flag_empty: assert property ((rx_pending_o == '0) [*3] |-> combined_rx_avail_n_o)
        else $error("combined receive flag low with all channels empty");
    a_tx_flag_full: assert property ($rose(combined_tx_space_n_o) |->
        $past(wr_strobe_i) || $past(wr_strobe_i, 2) || $past(wr_strobe_i, 3))
        else $error("combined transmit flag rose without a write");
    a_irq_gated_off: assert property ((IRQ_VARIANT != 2'h1 && (IRQ_VARIANT == 2'h2 || !irq_style_select_i) &&
        modem_control_reg_gate_i == '0) [*2] |-> irq_o == '0)
        else $error("interrupt raised while gated off");
    a_read_answer: assert property (rd_valid_o |-> $past(rd_strobe_i))
        else $error("read answer without a read strobe");
    a_err_sticky: assert property (($past(line_err_o) & ~line_err_o) != '0 |->
        $past(rd_strobe_i) || $past(rd_strobe_i, 2))
        else $error("line error cleared without a read");
endmodule : qu_top_assertions

/* File: tb/qu_serial_peer.sv */
// remote serial source for the four receive lines
module qu_serial_peer (
    input wire logic ref_clk_i,
    output logic [3:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial line_o = 4'hF;

    // odd parity frame, sixteen clocks a bit, parity flipped on request
    task automatic send(input int ch, input logic [7:0] b, input logic bad_par);
        logic [10:0] f;
        f = {1'h1, ~^b ^ bad_par, b, 1'h0};
        for (int i = 0; i < 11; i++) begin
            @(negedge ref_clk_i);
            line_o[ch] = f[i];
            repeat (15) @(negedge ref_clk_i);
        end
        @(negedge ref_clk_i);
        line_o[ch] = 1'h1;
    endtask : send
endmodule : qu_serial_peer

/* File: tb/tb_top.sv */
// self-checking bench for the quad channel serial core
`include "qu_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, rst_n_i, wr_strobe_i, rd_strobe_i, irq_style_select_i, rd_valid_o;
    logic combined_rx_avail_n_o, combined_tx_space_n_o;
    qu_pkg::qu_cfg_s cfg_i;
    qu_pkg::qu_sel_s sel_i;
    logic [7:0] wr_data_i, rd_data_o;
    logic [3:0] loopback_i, modem_control_reg_gate_i, serial_in_ch_i, serial_out_ch_o;
    logic [3:0] irq_o, line_err_o, rx_pending_o, irq_hi, irq_lo;
    logic [10:0] frm;
    int n_errors = 0;
    int cmp_count = 0;

    qu_top u_qu_top (.ref_clk_i, .rst_n_i, .cfg_i, .sel_i, .wr_strobe_i, .wr_data_i, .rd_strobe_i,
        .rd_data_o, .rd_valid_o, .loopback_i, .irq_style_select_i, .modem_control_reg_gate_i,
        .serial_in_ch_i, .serial_out_ch_o, .combined_rx_avail_n_o, .combined_tx_space_n_o,
        .irq_o, .line_err_o, .rx_pending_o);
    qu_serial_peer u_qu_serial_peer (.ref_clk_i, .line_o(serial_in_ch_i));
    qu_top #(.IRQ_VARIANT(`QU_STYLE_TIED_HIGH)) u_qu_top_tied_hi (.ref_clk_i, .rst_n_i, .cfg_i, .sel_i,
        .wr_strobe_i, .wr_data_i, .rd_strobe_i, .rd_data_o(), .rd_valid_o(), .loopback_i, .irq_style_select_i,
        .modem_control_reg_gate_i, .serial_in_ch_i, .serial_out_ch_o(), .combined_rx_avail_n_o(),
        .combined_tx_space_n_o(), .irq_o(irq_hi), .line_err_o(), .rx_pending_o());
    qu_top #(.IRQ_VARIANT(`QU_STYLE_TIED_LOW)) u_qu_top_tied_lo (.ref_clk_i, .rst_n_i, .cfg_i, .sel_i,
        .wr_strobe_i, .wr_data_i, .rd_strobe_i, .rd_data_o(), .rd_valid_o(), .loopback_i, .irq_style_select_i,
        .modem_control_reg_gate_i, .serial_in_ch_i, .serial_out_ch_o(), .combined_rx_avail_n_o(),
        .combined_tx_space_n_o(), .irq_o(irq_lo), .line_err_o(), .rx_pending_o());

    initial begin
        ref_clk_i = 1'h0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic pick(input int w, input int ch);
        case (w)
            0: return serial_out_ch_o[ch];
            1: return irq_o[ch];
            2: return rx_pending_o[ch];
            default: return line_err_o[ch];
        endcase
    endfunction : pick

    task automatic wait_bit(input int w, input int ch, input logic lvl);
        int k;
        for (k = 0; k < 4000 && pick(w, ch) !== lvl; k++) @(negedge ref_clk_i);
        if (k == 4000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t wait timed out", $time);
            print_verdict();
        end
    endtask : wait_bit

    // back-to-back writes, strobe held high across the burst
    task automatic wr_burst(input logic [7:0] first, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_i);
            wr_strobe_i = 1'h1;
            wr_data_i = first + 8'(i);
        end
        @(negedge ref_clk_i);
        wr_strobe_i = 1'h0;
    endtask : wr_burst

    task automatic rd(input logic [7:0] exp, input logic vld);
        @(negedge ref_clk_i);
        rd_strobe_i = 1'h1;
        @(negedge ref_clk_i);
        rd_strobe_i = 1'h0;
        chk(rd_valid_o, vld);
        if (vld) chk(rd_data_o, exp);
    endtask : rd

    task automatic get_frame(input int ch);
        wait_bit(0, ch, 1'h0);
        repeat (8) @(negedge ref_clk_i);
        for (int i = 0; i < 11; i++) begin
            frm[i] = serial_out_ch_o[ch];
            repeat (16) @(negedge ref_clk_i);
        end
    endtask : get_frame

    initial begin
        rst_n_i = 1'h0;
        wr_strobe_i = 1'h0;
        rd_strobe_i = 1'h0;
        wr_data_i = 8'h00;
        loopback_i = 4'h0;
        irq_style_select_i = 1'h1;
        modem_control_reg_gate_i = 4'h0;
        cfg_i = '{fifo_en: 1'h1, parity_en: 1'h1, parity_odd: 1'h1, two_stop: 1'h0, rx_trig: 2'h1,
            baud_div: 16'h0001};
        sel_i = '{mode_16: 1'h1, chan_cs_n: 4'hE, single_cs_n: 1'h1, chan_addr: 2'h0};
        repeat (5) @(negedge ref_clk_i);
        rst_n_i = 1'h1;
        @(negedge ref_clk_i);
        chk(serial_out_ch_o, 4'hF);
        chk(combined_rx_avail_n_o, 1'h1);
        chk(combined_tx_space_n_o, 1'h0);
        $display("test reset state done");

        wr_burst(8'hA5, 1);
        get_frame(0);
        chk(frm, {1'h1, ~^8'hA5, 8'hA5, 1'h0});
        chk(serial_out_ch_o, 4'hF);
        sel_i.chan_cs_n = 4'hF;
        wr_burst(8'h3C, 1);
        repeat (4) @(negedge ref_clk_i);
        chk(serial_out_ch_o, 4'hF);
        $display("test transmit frame done");

        sel_i = '{mode_16: 1'h0, chan_cs_n: 4'hF, single_cs_n: 1'h0, chan_addr: 2'h1};
        loopback_i = 4'h2;
        wr_burst(8'h10, 4);
        wait_bit(2, 1, 1'h1);
        chk(irq_o[1], 1'h0);
        chk(combined_rx_avail_n_o, 1'h0);
        wait_bit(1, 1, 1'h1);
        chk(serial_out_ch_o, 4'hF);
        chk(irq_lo[1], 1'h0);
        irq_style_select_i = 1'h0;
        repeat (3) @(negedge ref_clk_i);
        chk(irq_o[1], 1'h0);
        chk(irq_hi[1], 1'h1);
        modem_control_reg_gate_i = 4'h2;
        repeat (3) @(negedge ref_clk_i);
        chk(irq_o[1], 1'h1);
        chk(irq_lo[1], 1'h1);
        for (int i = 0; i < 4; i++) rd(8'h10 + 8'(i), 1'h1);
        rd(8'h00, 1'h0);
        repeat (3) @(negedge ref_clk_i);
        chk(combined_rx_avail_n_o, 1'h1);
        loopback_i = 4'h0;
        $display("test loop-back and interrupt done");

        sel_i = '{mode_16: 1'h1, chan_cs_n: 4'hB, single_cs_n: 1'h1, chan_addr: 2'h0};
        u_qu_serial_peer.send(2, 8'h5A, 1'h0);
        wait_bit(2, 2, 1'h1);
        chk(rx_pending_o, 4'h4);
        rd(8'h5A, 1'h1);
        chk(line_err_o[2], 1'h0);
        u_qu_serial_peer.send(2, 8'h77, 1'h1);
        wait_bit(3, 2, 1'h1);
        chk(line_err_o[2], 1'h1);
        $display("test serial receive done");

        // fifo-less: one holding location, second byte overruns
        cfg_i.fifo_en = 1'h0;
        loopback_i = 4'h2;
        sel_i.chan_cs_n = 4'hD;
        wr_burst(8'h21, 1);
        wr_burst(8'h22, 1);
        wait_bit(3, 1, 1'h1);
        chk(rx_pending_o, 4'h6);
        chk(irq_o, 4'h2);
        $display("test fifo-less mode done");

        rst_n_i = 1'h0;
        cfg_i.fifo_en = 1'h1;
        loopback_i = 4'h0;
        cfg_i.baud_div = 16'hFFFF;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'h1;
        for (int ch = 0; ch < 4; ch++) begin
            sel_i.chan_cs_n = ~(4'h1 << ch);
            chk(combined_tx_space_n_o, 1'h0);
            wr_burst(8'h40, 17);
            repeat (3) @(negedge ref_clk_i);
        end
        chk(combined_tx_space_n_o, 1'h1);
        $display("test transmit fill done");
        print_verdict();
    end
endmodule : tb_top

bind qu_top qu_top_assertions #(.CHANNELS(CHANNELS), .IRQ_VARIANT(IRQ_VARIANT)) u_qu_top_assertions (
    .ref_clk_i, .rst_n_i, .wr_strobe_i, .rd_strobe_i, .rd_valid_o, .loopback_i, .irq_style_select_i,
    .modem_control_reg_gate_i, .serial_out_ch_o, .combined_rx_avail_n_o, .combined_tx_space_n_o, .irq_o,
    .line_err_o, .rx_pending_o);
